// ==== logic/spc_port_clk_ctrl.sv ====
// Top of the port clock gating controller: APB register file, power mode
// tracking, enable selection, unclocked-port fault detection and interrupt.
// Assumes the power manager and the port bus decoder run on clk_sys_i, so
// their signals need no synchroniser.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
module spc_port_clk_ctrl (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [spc_pkg::SPC_AW-1:0] paddr_i,
    input wire logic [spc_pkg::SPC_DW-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [spc_pkg::SPC_DW-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Power manager
    input wire logic sleep_i,
    input wire logic deep_sleep_i,
    // Port bus decoder
    input wire logic port_access_i,
    input wire logic port_write_i,
    input wire logic [2:0] port_sel_i,
    output logic port_fault_o,
    // Port clock enables
    output logic [spc_pkg::SPC_PORTS-1:0] port_clock_enable_o,
    // Interrupt
    output logic irq_o
);
    import spc_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [SPC_PORTS-1:0] run_gate_q;
    logic [SPC_PORTS-1:0] run_gate_d;
    logic [SPC_PORTS-1:0] sleep_gate_q;
    logic [SPC_PORTS-1:0] sleep_gate_d;
    logic [SPC_PORTS-1:0] deep_gate_q;
    logic [SPC_PORTS-1:0] deep_gate_d;
    logic acg_q;
    logic acg_d;
    logic [SPC_PORTS-1:0] int_stat_q;
    logic [SPC_PORTS-1:0] int_stat_d;
    logic [SPC_PORTS-1:0] int_mask_q;
    logic [SPC_PORTS-1:0] int_mask_d;
    spc_mode_t mode_q;
    spc_mode_t mode_d;
    logic [2:0] info_port_q;
    logic [2:0] info_port_d;
    logic info_write_q;
    logic info_write_d;
    logic info_valid_q;
    logic info_valid_d;
    logic [SPC_COUNT_W-1:0] fault_cnt_q;
    logic [SPC_COUNT_W-1:0] fault_cnt_d;

    wire apb_access;
    wire apb_wr;
    wire apb_rd;
    wire hit_run;
    wire hit_sleep;
    wire hit_deep;
    wire hit_cfg;
    wire hit_stat;
    wire hit_mask;
    wire hit_state;
    wire hit_info;
    wire hit_any;
    wire low_lane;
    wire fault_now;
    wire [SPC_PORTS-1:0] fault_vec;
    wire [SPC_PORTS-1:0] enables;
    wire [SPC_DW-1:0] rd_mux;

    spc_sel_if sel_bus ();

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Only the low byte lane carries writable bits; upper lanes are
    // reserved and their strobes are ignored.
    function automatic logic [SPC_DW-1:0] spc_pad(
        input logic [SPC_PORTS-1:0] v
    );
        spc_pad = {{(SPC_DW - SPC_PORTS){1'b0}}, v};
    endfunction

    function automatic logic [SPC_PORTS-1:0] spc_wr_byte(
        input logic [SPC_PORTS-1:0] cur,
        input logic [SPC_DW-1:0] wd,
        input logic lane
    );
        spc_wr_byte = lane ? wd[SPC_PORTS-1:0] : cur;
    endfunction

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign apb_access = psel_i && penable_i;
    // Writes to unmapped offsets are dropped here, before any register
    // sees them.
    assign apb_wr = apb_access && pwrite_i && hit_any;
    assign apb_rd = apb_access && !pwrite_i;
    assign low_lane = pstrb_i[0];

    // All twelve address bits are decoded, so no register has an alias.
    assign hit_run = (paddr_i == SPC_RUN_GATE_OFS);
    assign hit_sleep = (paddr_i == SPC_SLEEP_GATE_OFS);
    assign hit_deep = (paddr_i == SPC_DEEP_GATE_OFS);
    assign hit_cfg = (paddr_i == SPC_CFG_OFS);
    assign hit_stat = (paddr_i == SPC_INT_STAT_OFS);
    assign hit_mask = (paddr_i == SPC_INT_MASK_OFS);
    assign hit_state = (paddr_i == SPC_STATE_OFS);
    assign hit_info = (paddr_i == SPC_FAULT_INFO_OFS);
    assign hit_any = hit_run || hit_sleep || hit_deep || hit_cfg ||
        hit_stat || hit_mask || hit_state || hit_info;

    // Zero wait state: every access completes in its first access cycle.
    assign pready_o = 1'b1;
    assign pslverr_o = apb_access && !hit_any;

    // ****************************************************************
    // Read data
    // ****************************************************************
    // The state word shows the enables actually applied, which trail a
    // gate write by one cycle.
    assign rd_mux =
        hit_run ? spc_pad(run_gate_q) :
        hit_sleep ? spc_pad(sleep_gate_q) :
        hit_deep ? spc_pad(deep_gate_q) :
        hit_cfg ? spc_pad({{(SPC_PORTS - 1){1'b0}}, acg_q}) :
        hit_stat ? spc_pad(int_stat_q) :
        hit_mask ? spc_pad(int_mask_q) :
        hit_state ? ({{(SPC_DW - SPC_STATE_MODE_LSB - 2){1'b0}},
            mode_q, enables}) :
        hit_info ? {fault_cnt_q,
            {(SPC_INFO_COUNT_LSB - SPC_INFO_VALID_BIT - 1){1'b0}},
            info_valid_q, info_write_q, info_port_q} :
        {SPC_DW{1'b0}};

    // Read data is combinational from flops so it is valid in the same
    // access cycle that pready is high.
    assign prdata_o = apb_rd ? rd_mux : {SPC_DW{1'b0}};

    // ****************************************************************
    // Gating registers and configuration
    // ****************************************************************
    assign run_gate_d = (apb_wr && hit_run) ?
        spc_wr_byte(run_gate_q, pwdata_i, low_lane) : run_gate_q;
    assign sleep_gate_d = (apb_wr && hit_sleep) ?
        spc_wr_byte(sleep_gate_q, pwdata_i, low_lane) : sleep_gate_q;
    assign deep_gate_d = (apb_wr && hit_deep) ?
        spc_wr_byte(deep_gate_q, pwdata_i, low_lane) : deep_gate_q;
    // Only bit 0 of the configuration word is stored; the rest read zero.
    assign acg_d = (apb_wr && hit_cfg && low_lane) ?
        pwdata_i[SPC_CFG_ACG_BIT] : acg_q;
    assign int_mask_d = (apb_wr && hit_mask) ?
        spc_wr_byte(int_mask_q, pwdata_i, low_lane) : int_mask_q;

    // One register to a process keeps each reset value beside its flop.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            run_gate_q <= SPC_GATE_RST;
        end else begin
            run_gate_q <= run_gate_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sleep_gate_q <= SPC_GATE_RST;
        end else begin
            sleep_gate_q <= sleep_gate_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            deep_gate_q <= SPC_GATE_RST;
        end else begin
            deep_gate_q <= deep_gate_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            acg_q <= SPC_ACG_RST;
        end else begin
            acg_q <= acg_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            int_mask_q <= SPC_MASK_RST;
        end else begin
            int_mask_q <= int_mask_d;
        end
    end

    // ****************************************************************
    // Power mode tracking
    // ****************************************************************
    // Deep sleep wins when both requests are high, since it is the
    // stricter state and the deep mask is the one software set for it.
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            SPC_MODE_RUN: begin
                if (deep_sleep_i) begin
                    mode_d = SPC_MODE_DEEP;
                end else if (sleep_i) begin
                    mode_d = SPC_MODE_SLEEP;
                end
            end
            SPC_MODE_SLEEP: begin
                if (deep_sleep_i) begin
                    mode_d = SPC_MODE_DEEP;
                end else if (!sleep_i) begin
                    mode_d = SPC_MODE_RUN;
                end
            end
            SPC_MODE_DEEP: begin
                if (!deep_sleep_i) begin
                    mode_d = sleep_i ? SPC_MODE_SLEEP : SPC_MODE_RUN;
                end
            end
            default: begin
                // An illegal code falls back to run on the next edge.
                mode_d = SPC_MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_q <= SPC_MODE_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ****************************************************************
    // Enable selection
    // ****************************************************************
    assign sel_bus.run_mask = run_gate_q;
    assign sel_bus.sleep_mask = sleep_gate_q;
    assign sel_bus.deep_mask = deep_gate_q;
    assign sel_bus.auto_clock_gating_enable = acg_q;
    assign sel_bus.mode = mode_q;
    assign enables = sel_bus.enable;

    // The selector registers its output, which adds the one cycle of lag
    // that software sees after a gate write.
    spc_gate_sel i_spc_gate_sel (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .sel(sel_bus.sel)
    );

    // A high enable keeps the port clocked; a low one stops its clock and
    // the port block holds itself disabled on that level.
    assign port_clock_enable_o = enables;

    // ****************************************************************
    // Unclocked port fault
    // ****************************************************************
    // The fault answers in the same cycle as the access, so the port bus
    // never waits on a port that has no clock to answer with.
    assign fault_now = port_access_i && !enables[port_sel_i];
    assign port_fault_o = fault_now;
    // One-hot of the faulted port, merged into the sticky status below.
    assign fault_vec = fault_now ?
        (SPC_PORTS'(1) << port_sel_i) : {SPC_PORTS{1'b0}};

    // Capture the first fault; later ones only bump the count until
    // software clears the status bits.
    assign info_valid_d = (fault_now || (info_valid_q && (int_stat_q != 0)));
    assign info_port_d = (fault_now && !info_valid_q) ? port_sel_i :
        info_port_q;
    assign info_write_d = (fault_now && !info_valid_q) ? port_write_i :
        info_write_q;
    // The count saturates rather than wraps, so a storm of faults never
    // reads back as a small number.
    assign fault_cnt_d = (fault_now && (fault_cnt_q != '1)) ?
        fault_cnt_q + SPC_COUNT_W'(1) : fault_cnt_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            info_valid_q <= 1'b0;
        end else begin
            info_valid_q <= info_valid_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            info_port_q <= 3'h0;
        end else begin
            info_port_q <= info_port_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            info_write_q <= 1'b0;
        end else begin
            info_write_q <= info_write_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            fault_cnt_q <= '0;
        end else begin
            fault_cnt_q <= fault_cnt_d;
        end
    end

    // ****************************************************************
    // Interrupt
    // ****************************************************************
    // Write one to clear; a fault in the same cycle as the clear wins.
    assign int_stat_d = fault_vec |
        (int_stat_q & ~((apb_wr && hit_stat && low_lane) ?
        pwdata_i[SPC_PORTS-1:0] : {SPC_PORTS{1'b0}}));

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            int_stat_q <= SPC_MASK_RST;
        end else begin
            int_stat_q <= int_stat_d;
        end
    end

    // A plain level from flops, so a mask write never makes it glitch.
    assign irq_o = |(int_stat_q & int_mask_q);

endmodule

// ==== pkg/spc_pkg.sv ====
// Package for the port clock gating controller: register map, fields,
// reset values and power mode encodings.
// Assumes a 32-bit APB register bus and a single 100 MHz system clock.
//
// Contract
// - Bits 0..7 gate ports A..H in order.
// - Set bit keeps that port clocked, working.
// - Clear bit stops port clock, holds it disabled.
// - Access to unclocked port answers with fault.
// - Sleep gating register resets to all zero.
// - Bits 31..8 read zero, ignore writes.
// - Run, sleep, deep-sleep registers select enables.
// - Sleep selections apply only with auto gating.
package spc_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int unsigned SPC_PORTS = 8;
    localparam int unsigned SPC_AW = 12;
    localparam int unsigned SPC_DW = 32;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [SPC_AW-1:0] SPC_RUN_GATE_OFS = 12'h108;
    localparam logic [SPC_AW-1:0] SPC_SLEEP_GATE_OFS = 12'h118;
    localparam logic [SPC_AW-1:0] SPC_DEEP_GATE_OFS = 12'h128;
    localparam logic [SPC_AW-1:0] SPC_CFG_OFS = 12'h200;
    localparam logic [SPC_AW-1:0] SPC_INT_STAT_OFS = 12'h204;
    localparam logic [SPC_AW-1:0] SPC_INT_MASK_OFS = 12'h208;
    localparam logic [SPC_AW-1:0] SPC_STATE_OFS = 12'h20c;
    localparam logic [SPC_AW-1:0] SPC_FAULT_INFO_OFS = 12'h210;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int unsigned SPC_CFG_ACG_BIT = 0;
    localparam int unsigned SPC_STATE_MODE_LSB = 8;
    localparam int unsigned SPC_INFO_PORT_LSB = 0;
    localparam int unsigned SPC_INFO_WRITE_BIT = 3;
    localparam int unsigned SPC_INFO_VALID_BIT = 4;
    localparam int unsigned SPC_INFO_COUNT_LSB = 16;
    localparam int unsigned SPC_COUNT_W = 16;
    localparam logic [SPC_PORTS-1:0] SPC_GATE_RST = 8'h00;
    localparam logic [SPC_PORTS-1:0] SPC_MASK_RST = 8'h00;
    localparam logic SPC_ACG_RST = 1'b0;

    // ****************************************************************
    // Power modes, Gray coded along run, sleep, deep sleep
    // ****************************************************************
    typedef enum logic [1:0] {
        SPC_MODE_RUN = 2'h0,
        SPC_MODE_SLEEP = 2'h1,
        SPC_MODE_DEEP = 2'h3
    } spc_mode_t;

endpackage

// ==== pkg/spc_sel_if.sv ====
// Interface carrying the three gating masks, the auto gating bit and the
// power mode into the enable selector, and the chosen enables back.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface spc_sel_if;
    import spc_pkg::*;

    logic [SPC_PORTS-1:0] run_mask;
    logic [SPC_PORTS-1:0] sleep_mask;
    logic [SPC_PORTS-1:0] deep_mask;
    logic auto_clock_gating_enable;
    spc_mode_t mode;
    logic [SPC_PORTS-1:0] enable;

    modport ctrl (
        output run_mask,
        output sleep_mask,
        output deep_mask,
        output auto_clock_gating_enable,
        output mode,
        input enable
    );

    modport sel (
        input run_mask,
        input sleep_mask,
        input deep_mask,
        input auto_clock_gating_enable,
        input mode,
        output enable
    );
endinterface

// ==== logic/spc_gate_sel.sv ====
// Chooses the per-port clock enables for the present power mode.
// Assumes the masks and mode are synchronous to clk_sys_i.
`timescale 1ns/10ps
module spc_gate_sel (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Selection carrier
    spc_sel_if.sel sel
);
    import spc_pkg::*;

    logic [SPC_PORTS-1:0] pick;
    logic [SPC_PORTS-1:0] enable_q;

    // ****************************************************************
    // Mode selection
    // ****************************************************************
    // Without auto gating the run mask stays in charge in every mode.
    assign pick = !sel.auto_clock_gating_enable ? sel.run_mask :
        (sel.mode == SPC_MODE_SLEEP) ? sel.sleep_mask :
        (sel.mode == SPC_MODE_DEEP) ? sel.deep_mask :
        sel.run_mask;

    // Registered so the enables never glitch into the clock gates.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            enable_q <= SPC_GATE_RST;
        end else begin
            enable_q <= pick;
        end
    end

    assign sel.enable = enable_q;
endmodule

// ==== sim/spc_port_clk_ctrl_props.sv ====
// Concurrent checks on the port clock gating controller's top ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module spc_port_clk_ctrl_props
    import spc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [SPC_AW-1:0] paddr_i,
    input wire logic [SPC_DW-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [SPC_DW-1:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Power manager and port bus
    input wire logic sleep_i,
    input wire logic deep_sleep_i,
    input wire logic port_access_i,
    input wire logic port_write_i,
    input wire logic [2:0] port_sel_i,
    input wire logic port_fault_o,
    input wire logic [SPC_PORTS-1:0] port_clock_enable_o,
    input wire logic irq_o
);
    // ****************************************************************
    // Shadow of the registers and the mode, rebuilt from the bus.
    // ****************************************************************
    logic [7:0] run_q, slp_q, dep_q, msk_q;
    logic acg_q;
    spc_mode_t mode_q;
    wire acc_w = psel_i & penable_i;
    wire wr_w = acc_w & pwrite_i & pstrb_i[0];
    wire [7:0] en_w = port_clock_enable_o;
    wire map_w = paddr_i inside {SPC_RUN_GATE_OFS, SPC_SLEEP_GATE_OFS,
        SPC_DEEP_GATE_OFS, SPC_CFG_OFS, SPC_INT_STAT_OFS, SPC_INT_MASK_OFS,
        SPC_STATE_OFS, SPC_FAULT_INFO_OFS};

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            {run_q, slp_q, dep_q, msk_q, acg_q} <= '0;
            mode_q <= SPC_MODE_RUN;
        end else begin
            if (wr_w && paddr_i == SPC_RUN_GATE_OFS) run_q <= pwdata_i[7:0];
            if (wr_w && paddr_i == SPC_SLEEP_GATE_OFS) slp_q <= pwdata_i[7:0];
            if (wr_w && paddr_i == SPC_DEEP_GATE_OFS) dep_q <= pwdata_i[7:0];
            if (wr_w && paddr_i == SPC_INT_MASK_OFS) msk_q <= pwdata_i[7:0];
            if (wr_w && paddr_i == SPC_CFG_OFS) acg_q <= pwdata_i[0];
            mode_q <= deep_sleep_i ? SPC_MODE_DEEP :
                sleep_i ? SPC_MODE_SLEEP : SPC_MODE_RUN;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    fault_gated_a: assert property (
        port_access_i && !en_w[port_sel_i] |-> port_fault_o)
        else $error("No fault on an access to a gated port.");
    fault_clocked_a: assert property (
        port_access_i && en_w[port_sel_i] |-> !port_fault_o)
        else $error("Fault on an access to a clocked port.");
    fault_idle_a: assert property (
        !port_access_i |-> !port_fault_o)
        else $error("Fault without a port access.");
    reset_clear_a: assert property (
        $fell(rst_i) |-> en_w == 8'h00 && irq_o == 1'b0)
        else $error("Enables or interrupt not clear after reset.");
    upper_zero_a: assert property (
        acc_w && !pwrite_i && paddr_i == SPC_SLEEP_GATE_OFS
        |-> prdata_o == {24'h000000, slp_q})
        else $error("Sleep gate read data wrong.");
    bad_addr_a: assert property (
        acc_w |-> pready_o && (pslverr_o == !map_w))
        else $error("Bus error response wrong for the address.");
    acg_off_a: assert property (
        !$past(acg_q) |-> en_w == $past(run_q))
        else $error("Run gate not applied with auto gating off.");
    run_sel_a: assert property (
        $past(acg_q && mode_q == SPC_MODE_RUN) |-> en_w == $past(run_q))
        else $error("Run gate not applied in run mode.");
    sleep_sel_a: assert property (
        $past(acg_q && mode_q == SPC_MODE_SLEEP) |-> en_w == $past(slp_q))
        else $error("Sleep gate not applied in sleep mode.");
    deep_sel_a: assert property (
        $past(acg_q && mode_q == SPC_MODE_DEEP) |-> en_w == $past(dep_q))
        else $error("Deep gate not applied in deep sleep.");
    irq_raise_a: assert property (
        port_fault_o && msk_q[port_sel_i] |=> irq_o)
        else $error("Unmasked fault did not raise the interrupt.");
endmodule

bind spc_port_clk_ctrl spc_port_clk_ctrl_props i_spc_port_clk_ctrl_props (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .sleep_i(sleep_i),
    .deep_sleep_i(deep_sleep_i), .port_access_i(port_access_i),
    .port_write_i(port_write_i), .port_sel_i(port_sel_i),
    .port_fault_o(port_fault_o), .irq_o(irq_o),
    .port_clock_enable_o(port_clock_enable_o));

// ==== sim/spc_port_clk_ctrl_test.sv ====
// Self-checking bench for the port clock gating controller.
// Assumes zero-wait APB and a port fault answered in the access cycle.
`timescale 1ns/10ps
module spc_port_clk_ctrl_test;
    import spc_pkg::*;
    logic clk_sys_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [SPC_AW-1:0] paddr_i;
    logic [SPC_DW-1:0] pwdata_i, prdata_o, rdat;
    logic [3:0] pstrb_i;
    logic sleep_i, deep_sleep_i, port_access_i, port_write_i;
    logic port_fault_o, irq_o, rerr;
    logic [2:0] port_sel_i;
    logic [SPC_PORTS-1:0] port_clock_enable_o;
    logic [SPC_AW-1:0] gofs [3];
    logic [31:0] gval [3];
    int miscompares = 0;
    int n_checks = 0;

    spc_port_clk_ctrl i_spc_port_clk_ctrl (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .sleep_i(sleep_i),
        .deep_sleep_i(deep_sleep_i), .port_access_i(port_access_i),
        .port_write_i(port_write_i), .port_sel_i(port_sel_i),
        .port_fault_o(port_fault_o), .irq_o(irq_o),
        .port_clock_enable_o(port_clock_enable_o));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic stop_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Reads take the data at the ready edge, before that edge's updates.
    task automatic apb(input logic w, input logic [SPC_AW-1:0] a,
                       input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic rdc(input logic [SPC_AW-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check("read data", rdat, e);
    endtask

    task automatic en_chk(input logic [31:0] e);
        @(posedge clk_sys_i);
        check("clock enables", 32'(port_clock_enable_o), e);
    endtask

    // The enables follow the mode inputs two edges later.
    task automatic set_mode(input logic s, input logic d);
        sleep_i <= s;
        deep_sleep_i <= d;
        repeat (2) @(posedge clk_sys_i);
    endtask

    task automatic poke(input logic [2:0] p, input logic f);
        port_sel_i <= p;
        port_write_i <= p[0];
        port_access_i <= 1'b1;
        @(posedge clk_sys_i);
        check("port fault", 32'(port_fault_o), 32'(f));
        port_access_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask

    initial begin
        #200000;
        miscompares++;
        stop_test();
    end

    initial begin
        {rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        {sleep_i, deep_sleep_i, port_access_i, port_write_i} = '0;
        rst_i = 1'b1;
        port_sel_i = 3'h0;
        pstrb_i = 4'hf;
        gofs = '{SPC_RUN_GATE_OFS, SPC_SLEEP_GATE_OFS, SPC_DEEP_GATE_OFS};
        gval = '{32'ha5, 32'h3c, 32'hc3};
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        for (int i = 0; i < 3; i++) rdc(gofs[i], 32'h0);
        en_chk(32'h0);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, gofs[i], 32'hffffff00 | gval[i]);
            rdc(gofs[i], gval[i]);
        end
        apb(1'b0, 12'h11c, 32'h0);
        check("unmapped error", 32'(rerr), 32'h1);
        $display("test registers done");
        set_mode(1'b1, 1'b0);
        en_chk(32'ha5);
        set_mode(1'b1, 1'b1);
        en_chk(32'ha5);
        apb(1'b1, SPC_CFG_OFS, 32'h1);
        en_chk(32'hc3);
        set_mode(1'b1, 1'b0);
        en_chk(32'h3c);
        set_mode(1'b0, 1'b0);
        en_chk(32'ha5);
        set_mode(1'b1, 1'b0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, SPC_SLEEP_GATE_OFS, 32'h1 << i);
            en_chk(32'h1 << i);
        end
        $display("test modes done");
        apb(1'b1, SPC_SLEEP_GATE_OFS, 32'h1);
        apb(1'b1, SPC_INT_MASK_OFS, 32'h2);
        poke(3'h0, 1'b0);
        poke(3'h1, 1'b1);
        check("irq", 32'(irq_o), 32'h1);
        rdc(SPC_INT_STAT_OFS, 32'h2);
        apb(1'b1, SPC_INT_STAT_OFS, 32'h2);
        @(posedge clk_sys_i);
        check("irq", 32'(irq_o), 32'h0);
        poke(3'h2, 1'b1);
        check("irq", 32'(irq_o), 32'h0);
        rdc(SPC_INT_STAT_OFS, 32'h4);
        rdc(SPC_STATE_OFS, 32'h101);
        rdc(SPC_FAULT_INFO_OFS, 32'h20012);
        rdc(SPC_SLEEP_GATE_OFS, 32'h1);
        apb(1'b1, SPC_SLEEP_GATE_OFS, rdat | 32'h2);
        rdc(SPC_SLEEP_GATE_OFS, 32'h3);
        en_chk(32'h3);
        $display("test faults done");
        stop_test();
    end
endmodule
